// ---- rtl/stap_defines.svh ----
// constants for the memory test access port
// assumes inclusion by bare name from stap_top
`ifndef STAP_DEFINES_SVH
`define STAP_DEFINES_SVH
`define STAP_IR_LEN 3
`define STAP_ID_LEN 32
`define STAP_BS_LEN 109
`define STAP_IR_EXTEST 3'h0
`define STAP_IR_IDREAD 3'h1
`define STAP_IR_FLOAT 3'h2
`define STAP_IR_SAMPLE 3'h4
`define STAP_IR_BYPASS 3'h7
`define STAP_IR_CAPTURE 3'h1
`define STAP_RESET_HOLD 5
`endif

// ---- rtl/stap_pkg.sv ----
// types for the memory test access port
// assumes stap_defines.svh is on the include path
package stap_pkg;
   typedef enum logic [3:0]
   {
      ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
      ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR,
      ST_EX2_IR, ST_UPD_IR
   } stap_state_t;
endpackage

// ---- rtl/stap_shreg.sv ----
// generic serial shift register with parallel capture
// assumes it runs on the test clock and is reset at power-up
`timescale 1ns/1ps
module stap_shreg #(
   parameter int WIDTH = 32
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // control
   input wire logic capture,
   input wire logic shift,
   input wire logic sin,
   input wire logic [WIDTH-1:0] pdata,
   // state
   output logic [WIDTH-1:0] q
);
   wire [WIDTH-1:0] next_q = capture ? pdata : (shift ? {sin, q[WIDTH-1:1]} : q);
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         q <= '0;
      else
         q <= next_q;
   end
endmodule

// ---- rtl/stap_top.sv ----
// boundary-scan test access port for a synchronous memory
// assumes tck is the link clock; rst is power-on reset only; pin pull-ups
// are modelled by treating absent-driver inputs as high in the pad ring
`timescale 1ns/1ps
`include "stap_defines.svh"
// Overview of operation
// [RULE1] sample inputs on rising test clock
// [RULE2] data output changes on falling clock
// [RULE3] mode select alone steers state machine
// [RULE4] state and instruction pick serial register
// [RULE5] five high mode-select edges force reset
// [RULE6] no separate test reset pin
// [RULE7] power-up forces reset state without clock
// [RULE8] floating inputs read high via pull-ups
// [RULE9] reset loads identification-read instruction
// [RULE10] bypass puts one-bit register in chain
// [RULE11] float instruction tristates outputs, captures inputs
// [RULE12] data output tristated outside shift states
module stap_top
   import stap_pkg::*;
#(
   parameter logic [`STAP_ID_LEN-1:0] ID_VALUE = 32'h0000_0001, // arbitrary value
   parameter int BS_LEN = `STAP_BS_LEN
)
(
   // memory-side clock and power-on reset
   input wire logic mclk,
   input wire logic rst,
   // test port pins
   input wire logic tck,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   output logic tdo_oe_n,
   // memory pins to sample and boundary drive
   input wire logic [BS_LEN-1:0] pin_in,
   output logic mem_float,
   output logic extest_drive
);
   // ==========================================================
   // state machine on the test clock
   stap_state_t state, next_state;
   logic [`STAP_IR_LEN-1:0] ir_sh, ir;
   logic bypass_bit;
   logic [2:0] tms_run;
   logic test_rst;
   // a local run-length guard backs up the walk; both agree on reset entry
   wire tms_reset = tms & (tms_run == 3'(`STAP_RESET_HOLD - 1));
   always_comb
   begin
      next_state = state;
      case (state) // [RULE3]
         ST_RESET: next_state = tms ? ST_RESET : ST_IDLE;
         ST_IDLE: next_state = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_DR: next_state = tms ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: next_state = tms ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: next_state = tms ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: next_state = tms ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: next_state = tms ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: next_state = tms ? ST_SEL_DR : ST_IDLE;
         ST_SEL_IR: next_state = tms ? ST_RESET : ST_CAP_IR;
         ST_CAP_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: next_state = tms ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: next_state = tms ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: next_state = tms ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: next_state = tms ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: next_state = tms ? ST_SEL_DR : ST_IDLE;
         default: next_state = ST_RESET;
      endcase
      if (tms_reset)
         next_state = ST_RESET; // [RULE5]
   end
   // only power-on reset clears the port; no separate test reset pin
   always_ff @(posedge tck or posedge rst) // [RULE1] [RULE6] [RULE7]
   begin
      if (rst)
         state <= ST_RESET;
      else
         state <= next_state;
   end
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
         tms_run <= 3'h0;
      else if (!tms)
         tms_run <= 3'h0;
      else if (!tms_reset)
         tms_run <= tms_run + 3'h1;
   end
   // ==========================================================
   // instruction register
   wire in_reset = (state == ST_RESET);
   wire cap_ir = (state == ST_CAP_IR);
   wire sh_ir = (state == ST_SH_IR);
   wire cap_dr = (state == ST_CAP_DR);
   wire sh_dr = (state == ST_SH_DR);
   wire [`STAP_IR_LEN-1:0] next_ir_sh = cap_ir ? `STAP_IR_CAPTURE :
      (sh_ir ? {tdi, ir_sh[`STAP_IR_LEN-1:1]} : ir_sh);
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
         ir_sh <= `STAP_IR_CAPTURE;
      else
         ir_sh <= next_ir_sh;
   end
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
         ir <= `STAP_IR_IDREAD; // [RULE9]
      else if (in_reset)
         ir <= `STAP_IR_IDREAD; // [RULE9]
      else if (state == ST_UPD_IR)
         ir <= ir_sh;
   end
   // ==========================================================
   // data registers
   wire sel_id = (ir == `STAP_IR_IDREAD);
   wire ir_float = (ir == `STAP_IR_FLOAT);
   wire ir_extest = (ir == `STAP_IR_EXTEST);
   wire sel_bs = ir_extest || ir_float || (ir == `STAP_IR_SAMPLE);
   // reserved codes fall back to bypass so the chain length stays defined
   wire sel_bp = !sel_id && !sel_bs;
   logic [`STAP_ID_LEN-1:0] id_q;
   logic [BS_LEN-1:0] bs_q;
   stap_shreg #(.WIDTH(`STAP_ID_LEN)) u_id
   (
      .clk(tck),
      .rst(rst),
      .capture(cap_dr && sel_id),
      .shift(sh_dr && sel_id),
      .sin(tdi),
      .pdata(ID_VALUE),
      .q(id_q)
   );
   // memory pins move on the memory clock; two stages keep a torn capture
   // out of the chain, at the cost of two tck edges of latency
   logic [BS_LEN-1:0] pin_meta, pin_sync;
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
      end
   end
   stap_shreg #(.WIDTH(BS_LEN)) u_bs
   (
      .clk(tck),
      .rst(rst),
      .capture(cap_dr && sel_bs), // [RULE11]
      .shift(sh_dr && sel_bs),
      .sin(tdi),
      .pdata(pin_sync),
      .q(bs_q)
   );
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
         bypass_bit <= 1'b0;
      else if (cap_dr)
         bypass_bit <= 1'b0;
      else if (sh_dr && sel_bp)
         bypass_bit <= tdi; // [RULE10]
   end
   // ==========================================================
   // output on the falling edge
   wire dr_bit = sel_id ? id_q[0] : (sel_bs ? bs_q[0] : bypass_bit);
   wire next_tdo = sh_ir ? ir_sh[0] : dr_bit; // [RULE4]
   logic float_tck, extest_tck, float_meta, extest_meta, tdo_at_rise;
   always_ff @(negedge tck or posedge rst) // [RULE2]
   begin
      if (rst)
      begin
         tdo <= 1'b0;
         tdo_oe_n <= 1'b1;
         float_tck <= 1'b0;
         extest_tck <= 1'b0;
      end
      else
      begin
         tdo <= next_tdo;
         tdo_oe_n <= !(sh_ir || sh_dr); // [RULE12]
         float_tck <= ir_float; // [RULE11]
         extest_tck <= ir_extest;
      end
   end
   // [RULE8] pull-ups sit in the pad ring; a floating tms reads high here
   // ==========================================================
   // instruction levels into the memory clock domain
   // both are quasi-static levels, so two plain stages are enough;
   // the memory sees a new instruction two memory clocks late
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         float_meta <= 1'b0;
         extest_meta <= 1'b0;
         mem_float <= 1'b0;
         extest_drive <= 1'b0;
      end
      else
      begin
         float_meta <= float_tck;
         extest_meta <= extest_tck;
         mem_float <= float_meta; // [RULE11]
         extest_drive <= extest_meta;
      end
   end
   // rising-edge copy of tdo, read only by the output-edge check
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
         tdo_at_rise <= 1'b0;
      else
         tdo_at_rise <= tdo;
   end
   // ==========================================================
   // checks
   reset_hold_a: assert property (@(posedge tck) disable iff (rst) // [RULE5]
      tms [*5] |=> state == ST_RESET) else $error("no reset after five tms high");
   id_default_a: assert property (@(posedge tck) disable iff (rst) // [RULE9]
      state == ST_RESET |=> ir == `STAP_IR_IDREAD) else $error("ir not idcode");
   oe_shift_a: assert property (@(posedge tck) disable iff (rst) // [RULE12]
      !(sh_ir || sh_dr) |-> tdo_oe_n) else $error("tdo enabled off shift");
   oe_drive_a: assert property (@(posedge tck) disable iff (rst) // [RULE12]
      (sh_ir || sh_dr) |-> !tdo_oe_n) else $error("tdo not enabled in shift");
   float_out_a: assert property (@(posedge tck) disable iff (rst) // [RULE11]
      ir_float && $stable(ir) |-> float_tck) else $error("no float");
   float_sync_a: assert property (@(posedge mclk) disable iff (rst) // [RULE11]
      mem_float == $past(float_tck, 2)) else $error("float level late");
   bypass_len_a: assert property (@(posedge tck) disable iff (rst) // [RULE10]
      sh_dr && sel_bp ##1 sh_dr |-> bypass_bit == $past(tdi))
      else $error("bypass bit wrong");
   tdo_stable_a: assert property (@(negedge tck) disable iff (rst) // [RULE2]
      tdo == tdo_at_rise) else $error("tdo moved on rising edge");
   chain_sel_a: assert property (@(posedge tck) disable iff (rst) // [RULE4]
      sh_ir |-> tdo == ir_sh[0]) else $error("wrong chain");
   chain_dr_a: assert property (@(posedge tck) disable iff (rst) // [RULE4]
      sh_dr |-> tdo == dr_bit) else $error("wrong data chain");
   idle_walk_a: assert property (@(posedge tck) disable iff (rst) // [RULE3]
      state == ST_RESET && !tms |=> state == ST_IDLE) else $error("bad walk");
endmodule

// ---- test/stap_ctrl_model.sv ----
// board test controller model: makes tck, drives tms and tdi, reads the tdo wire
// assumes tck stands still between bits and tdi floats high by its pull-up
`timescale 1ns/1ps
module stap_ctrl_model
(
   // test port
   output logic tck,
   output logic tms,
   output logic tdi,
   input wire logic tdo
);
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end
   // ==========
   // one bit at 80 ns: set up while low, read tdo just before the rise
   task automatic step(input logic m, input logic d, output logic q);
   begin
      tms = m;
      tdi = d;
      #40;
      q = tdo;
      tck = 1'b1;
      #40;
      tck = 1'b0;
   end
   endtask
endmodule

// ---- test/tb.sv ----
// self-checking bench for the memory test access port
// assumes the controller model owns tck; mclk and rst come from here
`timescale 1ns/1ps
module tb;
   localparam int BS = 109;
   localparam logic [31:0] ID = 32'h5A3C_0E71; // arbitrary value
   localparam logic [127:0] PINS = {4{32'hC3A5_0F69}};
   localparam logic [127:0] DIN = {4{32'h96E1_4B2D}};
   logic mclk, rst, tck, tms, tdi, tdo, tdo_oe_n, mem_float, extest_drive, q;
   logic [BS-1:0] pin_in;
   wire tdo_pin;
   int mismatches = 0;
   int tests_run = 0;
   // tristated tdo reads as z on the wire
   assign tdo_pin = tdo_oe_n ? 1'bz : tdo;
   stap_top #(.ID_VALUE(ID), .BS_LEN(BS)) stap_top_inst (.mclk(mclk), .rst(rst), .tck(tck),
      .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in),
      .mem_float(mem_float), .extest_drive(extest_drive));
   stap_ctrl_model stap_ctrl_model_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo_pin));
   // ==========
   // helpers
   task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
   begin
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   end
   endtask
   task automatic stop_test();
   begin
      if (mismatches == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   // the instruction levels reach the memory side two memory clocks late
   task automatic settle();
   begin
      repeat (3) @(posedge mclk);
      #1;
   end
   endtask
   task automatic walk(input logic [7:0] pat, input int n);
   begin
      for (int i = 0; i < n; i++)
         stap_ctrl_model_inst.step(pat[i], 1'b1, q);
   end
   endtask
   task automatic load_ir(input logic [2:0] code);
      logic [2:0] cap;
   begin
      walk(8'h03, 4);
      for (int i = 0; i < 3; i++)
      begin
         stap_ctrl_model_inst.step(i == 2, code[i], q);
         cap[i] = q;
      end
      walk(8'h01, 2);
      #5;
      check("ir capture", cap, 3'h1);
   end
   endtask
   task automatic scan_dr(input int n, output logic [127:0] dout);
   begin
      dout = '0;
      walk(8'h01, 3);
      for (int i = 0; i < n; i++)
      begin
         stap_ctrl_model_inst.step(i == n - 1, DIN[i], q);
         dout[i] = q;
      end
      walk(8'h01, 2);
   end
   endtask
   // ==========
   // scenarios
   task automatic do_reset();
   begin
      rst = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      check("oe in reset", tdo_oe_n, 1'b1);
      check("float in reset", mem_float, 1'b0);
      check("extest in reset", extest_drive, 1'b0);
      rst = 1'b0;
      // leave test-logic-reset so each scenario starts from idle
      stap_ctrl_model_inst.step(1'b0, 1'b1, q);
   end
   endtask
   task automatic id_scan();
      logic [127:0] got;
   begin
      scan_dr(32, got);
      check("id scan", got, ID);
      stap_ctrl_model_inst.step(1'b0, 1'b1, q);
      check("idle tdo", q, 1'bz);
   end
   endtask
   task automatic modes();
      logic [2:0] codes [6] = '{3'h0, 3'h2, 3'h4, 3'h7, 3'h5, 3'h1};
      logic [127:0] got, exp, mask;
      int n;
   begin
      for (int k = 0; k < 6; k++)
      begin
         load_ir(codes[k]);
         settle();
         check("float", mem_float, codes[k] == 3'h2);
         check("extest", extest_drive, codes[k] == 3'h0);
         n = (codes[k] == 3'h7 || codes[k] == 3'h5) ? 8 : (codes[k] == 3'h1 ? 32 : BS);
         exp = n == 8 ? {DIN[126:0], 1'b0} : (n == 32 ? {96'h0, ID} : PINS);
         mask = (128'h1 << n) - 128'h1;
         scan_dr(n, got);
         check("dr scan", got & mask, exp & mask);
      end
   end
   endtask
   task automatic tms_reset();
   begin
      load_ir(3'h7);
      walk(8'hF9, 8);
      walk(8'h00, 1);
      id_scan();
   end
   endtask
   // ==========
   // clock and main sequence
   initial
   begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   initial
   begin
      #900000;
      mismatches++;
      stop_test();
   end
   initial
   begin
      rst = 1'b1;
      pin_in = PINS[BS-1:0];
      do_reset();
      id_scan();
      modes();
      // reset in mid-run with the float instruction standing
      load_ir(3'h2);
      settle();
      check("float before reset", mem_float, 1'b1);
      do_reset();
      id_scan();
      tms_reset();
      stop_test();
   end
endmodule
